// [logic/timer16_capture_compare.sv]
// 16-bit up-counter with two compare and two capture registers
`timescale 1ns/1ps

module timer16_capture_compare (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// count control
	input wire logic count_tick,
	input wire logic timer_run,
	input wire logic prescaler_run,
	input wire logic count_src_sel,
	input wire logic clear_enable,
	// capture control
	input wire logic [1:0] capture_mode_field,
	input wire logic soft_capture_wr,
	// compare register writes
	input wire logic duty_buffer_enable,
	input wire logic duty_wr,
	input wire logic [15:0] duty_wdata,
	input wire logic period_wr,
	input wire logic [15:0] period_wdata,
	// toggle flip-flop control
	input wire logic cap_b_toggle_en,
	input wire logic cap_a_toggle_en,
	input wire logic period_toggle_en,
	input wire logic duty_toggle_en,
	input wire logic ff_ctrl_wr,
	input wire logic [1:0] ff_ctrl_code,
	input wire logic out_enable,
	// trigger sources
	input wire logic trigger_in_a,
	input wire logic trigger_in_b,
	input wire logic byte_timer_toggle_ff,
	// register contents
	output logic [15:0] up_counter,
	output logic [15:0] capture_reg_a,
	output logic [15:0] capture_reg_b,
	output logic [15:0] compare_duty_reg,
	output logic [15:0] duty_buffer,
	output logic [15:0] compare_period_reg,
	// toggle flip-flop and pin
	output logic output_toggle_ff,
	output logic pulse_out_pin,
	// interrupt pulses
	output logic duty_match_irq,
	output logic period_match_irq,
	output logic ext_irq_a,
	output logic ext_irq_b
);

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] cap_a;
		logic [15:0] cap_b;
		logic [15:0] duty;
		logic [15:0] dbuf;
		logic [15:0] period;
		logic tff;
		logic pin;
		logic duty_irq;
		logic period_irq;
		logic irq_a;
		logic irq_b;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic bt_rise;
	logic bt_fall;
	logic count_en;
	logic duty_hit;
	logic period_hit;
	logic load_a;
	logic load_b;
	logic soft_cap;
	logic toggle_odd;

	// ---------------------------------------------------------------
	// reset release through two flip-flops
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ---------------------------------------------------------------
	// edge detectors: pins synchronised, byte timer on same clock
	// ---------------------------------------------------------------
	edge_detect #(.USE_SYNC(1'b1)) u_edge_a (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(trigger_in_a),
		.rise(a_rise),
		.fall(a_fall),
		.level()
	);

	edge_detect #(.USE_SYNC(1'b1)) u_edge_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(trigger_in_b),
		.rise(b_rise),
		.fall(),
		.level()
	);

	edge_detect #(.USE_SYNC(1'b0)) u_edge_bt (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(byte_timer_toggle_ff),
		.rise(bt_rise),
		.fall(bt_fall),
		.level()
	);

	// ---------------------------------------------------------------
	// event decode
	// ---------------------------------------------------------------
	// count source: prescaled tick or pin A rising edge
	assign count_en = timer_run & prescaler_run &
		((count_src_sel == tcc_pkg::CSRC_PIN_A) ? a_rise : count_tick);

	// comparator matches are taken on the count that leaves the matched value
	assign duty_hit = count_en & (st_r.cnt == st_r.duty);
	assign period_hit = count_en & (st_r.cnt == st_r.period);

	// capture triggers by mode; mode 00 loads nothing
	always_comb
	begin
		load_a = 1'b0;
		load_b = 1'b0;
		case (capture_mode_field)
			tcc_pkg::CAPM_DIFF:
			begin
				load_a = a_rise;
				load_b = b_rise;
			end
			tcc_pkg::CAPM_WIDTH:
			begin
				load_a = a_rise;
				load_b = a_fall;
			end
			tcc_pkg::CAPM_FREQ:
			begin
				load_a = bt_rise;
				load_b = bt_fall;
			end
			default:
			begin
				load_a = 1'b0;
				load_b = 1'b0;
			end
		endcase
	end

	// software capture needs the prescaler running
	assign soft_cap = soft_capture_wr & prescaler_run;

	// odd number of enabled events inverts the flip-flop once
	assign toggle_odd = ^{duty_hit & duty_toggle_en, period_hit & period_toggle_en,
		(load_a | soft_cap) & cap_a_toggle_en, load_b & cap_b_toggle_en};

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// up-counter with optional clear on period match
		if (count_en)
		begin
			if (period_hit && clear_enable)
				st_nxt.cnt = tcc_pkg::CNT_RST;
			else
				st_nxt.cnt = st_r.cnt + 16'h0001;
		end
		// captures latch the counter value
		if (load_a || soft_cap)
			st_nxt.cap_a = st_r.cnt;
		if (load_b)
			st_nxt.cap_b = st_r.cnt;
		// duty write always loads the buffer, and the register too unless double buffering
		if (duty_wr)
		begin
			st_nxt.dbuf = duty_wdata;
			if (!duty_buffer_enable)
				st_nxt.duty = duty_wdata;
		end
		if (period_hit && duty_buffer_enable)
			st_nxt.duty = st_r.dbuf;
		if (period_wr)
			st_nxt.period = period_wdata;
		// toggle flip-flop: software command other than keep wins over events
		if (ff_ctrl_wr && ff_ctrl_code != tcc_pkg::FFC_KEEP)
		begin
			case (ff_ctrl_code)
				tcc_pkg::FFC_INVERT: st_nxt.tff = ~st_r.tff;
				tcc_pkg::FFC_SET: st_nxt.tff = 1'b1;
				default: st_nxt.tff = 1'b0;
			endcase
		end
		else if (toggle_odd)
			st_nxt.tff = ~st_r.tff;
		st_nxt.pin = out_enable & st_nxt.tff;
		// interrupt pulses
		st_nxt.duty_irq = duty_hit;
		st_nxt.period_irq = period_hit;
		st_nxt.irq_a = (capture_mode_field == tcc_pkg::CAPM_WIDTH) ? a_fall : a_rise;
		st_nxt.irq_b = b_rise;
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.cnt <= tcc_pkg::CNT_RST;
			st_r.cap_a <= tcc_pkg::CAP_RST;
			st_r.cap_b <= tcc_pkg::CAP_RST;
			st_r.duty <= tcc_pkg::CMP_RST;
			st_r.dbuf <= tcc_pkg::CMP_RST;
			st_r.period <= tcc_pkg::CMP_RST;
			st_r.tff <= tcc_pkg::TFF_RST;
		end
		else
			st_r <= st_nxt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign up_counter = st_r.cnt;
	assign capture_reg_a = st_r.cap_a;
	assign capture_reg_b = st_r.cap_b;
	assign compare_duty_reg = st_r.duty;
	assign duty_buffer = st_r.dbuf;
	assign compare_period_reg = st_r.period;
	assign output_toggle_ff = st_r.tff;
	assign pulse_out_pin = st_r.pin;
	assign duty_match_irq = st_r.duty_irq;
	assign period_match_irq = st_r.period_irq;
	assign ext_irq_a = st_r.irq_a;
	assign ext_irq_b = st_r.irq_b;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_period_clear: assert property (period_hit && clear_enable |=> up_counter == 16'h0000)
		else $error("counter not cleared on period match");
	a_free_run: assert property (count_en && !clear_enable |=> up_counter == $past(up_counter) + 16'h0001)
		else $error("free-running counter did not advance");
	a_duty_irq: assert property (count_en && up_counter == compare_duty_reg |=> duty_match_irq)
		else $error("duty match interrupt missing");
	a_period_irq: assert property (!$past(period_hit) |-> !period_match_irq)
		else $error("period interrupt without match");
	a_dbuf_move: assert property (period_hit && duty_buffer_enable |=> compare_duty_reg == $past(duty_buffer))
		else $error("buffered duty not moved on period match");
	a_cap_diff: assert property (capture_mode_field == 2'h1 && b_rise |=> capture_reg_b == $past(up_counter) && ext_irq_b)
		else $error("time difference capture B wrong");
	a_cap_rise_a: assert property (capture_mode_field == 2'h1 && a_rise |=> capture_reg_a == $past(up_counter))
		else $error("capture A not loaded on pin rise");
	a_cap_width: assert property (capture_mode_field == 2'h2 && a_fall |=> capture_reg_b == $past(up_counter) && ext_irq_a)
		else $error("pulse width capture B or irq wrong");
	a_irq_a_rise: assert property (capture_mode_field != 2'h2 && a_fall && !a_rise |=> !ext_irq_a)
		else $error("irq A on fall outside width mode");
	a_cap_freq: assert property (capture_mode_field == 2'h3 && bt_fall |=> capture_reg_b == $past(up_counter))
		else $error("frequency capture B wrong");
	a_cap_off: assert property (capture_mode_field == 2'h0 |=> $stable(capture_reg_b))
		else $error("capture B loaded while disabled");
	a_soft_cap: assert property (soft_capture_wr && prescaler_run |=> capture_reg_a == $past(up_counter))
		else $error("software capture failed");
	a_tff_hold: assert property (!toggle_odd && !ff_ctrl_wr |=> $stable(output_toggle_ff))
		else $error("toggle flip-flop changed without event");
	a_pin_gate: assert property (!out_enable |=> !pulse_out_pin)
		else $error("pin driven while output disabled");

	c_period_wrap: cover property (period_hit && clear_enable ##1 up_counter == 16'h0000);
	c_dbuf_move: cover property (period_hit && duty_buffer_enable);
	c_width_pair: cover property (capture_mode_field == 2'h2 && a_rise ##[1:50] a_fall);
	c_tff_toggle: cover property (toggle_odd ##1 $changed(output_toggle_ff));

endmodule

// [pkg/tcc_pkg.sv]
// constants shared by the 16-bit capture/compare timer
package tcc_pkg;

	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] CAP_RST = 16'h0000;
	localparam logic TFF_RST = 1'b0;

	// ---------------------------------------------------------------
	// capture mode field codes
	// ---------------------------------------------------------------
	localparam logic [1:0] CAPM_OFF = 2'h0;
	localparam logic [1:0] CAPM_DIFF = 2'h1;
	localparam logic [1:0] CAPM_WIDTH = 2'h2;
	localparam logic [1:0] CAPM_FREQ = 2'h3;

	// ---------------------------------------------------------------
	// toggle flip-flop control codes
	// ---------------------------------------------------------------
	localparam logic [1:0] FFC_INVERT = 2'h0;
	localparam logic [1:0] FFC_SET = 2'h1;
	localparam logic [1:0] FFC_CLEAR = 2'h2;
	localparam logic [1:0] FFC_KEEP = 2'h3;

	// ---------------------------------------------------------------
	// count source select
	// ---------------------------------------------------------------
	localparam logic CSRC_TICK = 1'b0;
	localparam logic CSRC_PIN_A = 1'b1;

endpackage

// [logic/edge_detect.sv]
// optional two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps

module edge_detect #(
	parameter bit USE_SYNC = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// sampled signal
	input wire logic din,
	// detected edges and settled level
	output logic rise,
	output logic fall,
	output logic level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} edge_s;

	edge_s st_r;
	edge_s st_nxt;
	logic lvl;

	// ---------------------------------------------------------------
	// level choice: synchronised copy or direct same-clock input
	// ---------------------------------------------------------------
	generate
		if (USE_SYNC)
		begin : g_sync
			assign lvl = st_r.s2;
		end
		else
		begin : g_direct
			assign lvl = din;
		end
	endgenerate

	// next state: first stage feeds only the second stage
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = lvl;
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// edge outputs
	assign rise = lvl & ~st_r.prev;
	assign fall = ~lvl & st_r.prev;
	assign level = lvl;

endmodule

// [testbench/pulse_source.sv]
// model of the external pulse sources that feed the trigger pins
`timescale 1ns/1ps

module pulse_source (
	// clock
	input wire logic mclk,
	// driven trigger lines
	output logic trigger_in_a,
	output logic trigger_in_b,
	output logic byte_timer_toggle_ff
);
	// ---------------------------------------------------------------
	// line drivers
	// ---------------------------------------------------------------
	// all sources idle low from time zero
	initial
	begin
		trigger_in_a = 1'b0;
		trigger_in_b = 1'b0;
		byte_timer_toggle_ff = 1'b0;
	end

	// put one source at a level just after an edge and hold it n cycles
	task drive(input int sel, input logic v, input int n);
		if (sel == 0)
			trigger_in_a = v;
		else if (sel == 1)
			trigger_in_b = v;
		else
			byte_timer_toggle_ff = v;
		repeat (n) @(posedge mclk);
		#1;
	endtask
endmodule

// [testbench/test_timer16_capture_compare.sv]
// self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps

module test_timer16_capture_compare;
	logic mclk, nrst, count_tick, timer_run, prescaler_run, count_src_sel, clear_enable;
	logic [1:0] capture_mode_field, ff_ctrl_code;
	logic soft_capture_wr, duty_buffer_enable, duty_wr, period_wr, ff_ctrl_wr, out_enable;
	logic [15:0] duty_wdata, period_wdata;
	logic cap_b_toggle_en, cap_a_toggle_en, period_toggle_en, duty_toggle_en;
	logic trigger_in_a, trigger_in_b, byte_timer_toggle_ff;
	logic [15:0] up_counter, capture_reg_a, capture_reg_b, compare_duty_reg, duty_buffer, compare_period_reg;
	logic output_toggle_ff, pulse_out_pin, duty_match_irq, period_match_irq, ext_irq_a, ext_irq_b;
	logic [15:0] c, p;
	int fail_count = 0;
	int check_count = 0;
	int na = 0;
	int nb = 0;
	int irq_a_n = 0;
	int irq_b_n = 0;

	timer16_capture_compare u_timer16_capture_compare (.*);
	pulse_source u_pulse_source (.*);

	// ---------------------------------------------------------------
	// clock, interrupt counting, watchdog
	// ---------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// tally external interrupt pulses mid-cycle, away from the launching edge
	always @(negedge mclk)
	begin
		if (ext_irq_a === 1'b1) irq_a_n++;
		if (ext_irq_b === 1'b1) irq_b_n++;
	end

	// cut a hang short well beyond the expected run length
	initial
	begin
		#150000;
		fail_count++;
		complete_run();
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task chk(input logic [15:0] e, input logic [15:0] g, input string n);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// wait a bounded time for a match interrupt, period one if per
	task wait_irq(input bit per);
		for (int i = 0; i < 300; i++)
		begin
			if ((per ? period_match_irq : duty_match_irq) === 1'b1) break;
			step(1);
		end
		chk(16'h0001, {15'h0000, per ? period_match_irq : duty_match_irq}, "match irq");
	endtask

	// one-cycle strobe: 0 duty, 1 period, 2 soft capture, 3 flip-flop command
	task pulse_wr(input int w);
		if (w == 0) duty_wr = 1'b1;
		else if (w == 1) period_wr = 1'b1;
		else if (w == 2) soft_capture_wr = 1'b1;
		else ff_ctrl_wr = 1'b1;
		step(1);
		{duty_wr, period_wr, soft_capture_wr, ff_ctrl_wr} = 4'h0;
		step(1);
	endtask

	task complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial
	begin
		{nrst, timer_run, count_src_sel, clear_enable, soft_capture_wr, duty_buffer_enable} = 6'h00;
		{duty_wr, period_wr, ff_ctrl_wr, out_enable, ff_ctrl_code, capture_mode_field} = 8'h00;
		{cap_b_toggle_en, cap_a_toggle_en, period_toggle_en, duty_toggle_en} = 4'h0;
		{count_tick, prescaler_run} = 2'h3;
		duty_wdata = 16'h0000;
		period_wdata = 16'h0000;
		step(10);
		nrst = 1'b1;
		step(5);
		chk(16'h0000, capture_reg_a | capture_reg_b | up_counter, "reset regs");
		chk(16'h0000, {14'h0000, output_toggle_ff, pulse_out_pin}, "reset tff");
		timer_run = 1'b1;
		// mode 00 ignores trigger edges
		u_pulse_source.drive(0, 1'b1, 6);
		u_pulse_source.drive(0, 1'b0, 6);
		chk(16'h0000, capture_reg_a, "cap a mode 00");
		// time difference between pin rises
		capture_mode_field = 2'h1;
		na = irq_a_n;
		nb = irq_b_n;
		u_pulse_source.drive(0, 1'b1, 9);
		u_pulse_source.drive(1, 1'b1, 6);
		u_pulse_source.drive(0, 1'b0, 1);
		u_pulse_source.drive(1, 1'b0, 6);
		chk(16'h0009, capture_reg_b - capture_reg_a, "diff capture");
		chk(16'(nb + 1), 16'(irq_b_n), "irq b count");
		chk(16'(na + 1), 16'(irq_a_n), "irq a on rise");
		// pulse width, irq a only on the fall
		capture_mode_field = 2'h2;
		na = irq_a_n;
		u_pulse_source.drive(0, 1'b1, 13);
		chk(16'(na), 16'(irq_a_n), "irq a no rise");
		u_pulse_source.drive(0, 1'b0, 6);
		chk(16'h000D, capture_reg_b - capture_reg_a, "width capture");
		chk(16'(na + 1), 16'(irq_a_n), "irq a on fall");
		// byte timer flip-flop edges
		capture_mode_field = 2'h3;
		u_pulse_source.drive(2, 1'b1, 7);
		u_pulse_source.drive(2, 1'b0, 4);
		chk(16'h0007, capture_reg_b - capture_reg_a, "freq capture");
		// software capture, refused with prescaler stopped
		capture_mode_field = 2'h0;
		prescaler_run = 1'b0;
		c = capture_reg_a;
		pulse_wr(2);
		chk(c, capture_reg_a, "soft cap stopped");
		prescaler_run = 1'b1;
		step(1);
		c = up_counter;
		pulse_wr(2);
		chk(c, capture_reg_a, "soft cap");
		// pin a as the count clock
		count_src_sel = 1'b1;
		step(2);
		c = up_counter;
		repeat (3)
		begin
			u_pulse_source.drive(0, 1'b1, 2);
			u_pulse_source.drive(0, 1'b0, 2);
		end
		u_pulse_source.drive(0, 1'b0, 5);
		chk(c + 16'h0003, up_counter, "pin count");
		count_src_sel = 1'b0;
		// duty match toggles, period match clears and reloads duty
		clear_enable = 1'b1;
		{duty_toggle_en, out_enable} = 2'h3;
		c = up_counter + 16'h000A;
		p = up_counter + 16'h0014;
		duty_wdata = c;
		pulse_wr(0);
		period_wdata = p;
		pulse_wr(1);
		chk(p, compare_period_reg, "period reg");
		wait_irq(1'b0);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "duty toggle");
		duty_buffer_enable = 1'b1;
		duty_wdata = 16'h0004;
		pulse_wr(0);
		chk(c, compare_duty_reg, "duty held");
		chk(16'h0004, duty_buffer, "duty buffer");
		wait_irq(1'b1);
		chk(16'h0000, up_counter, "period clear");
		chk(16'h0004, compare_duty_reg, "duty reload");
		chk(16'h0001, {15'h0000, output_toggle_ff}, "no period toggle");
		out_enable = 1'b0;
		step(1);
		chk(16'h0002, {14'h0000, output_toggle_ff, pulse_out_pin}, "pin gated");
		wait_irq(1'b0);
		chk(16'h0000, {14'h0000, output_toggle_ff, pulse_out_pin}, "pin off");
		clear_enable = 1'b0;
		wait_irq(1'b1);
		chk(p + 16'h0001, up_counter, "free run");
		// software commands on the toggle flip-flop, with all toggle events disabled
		{duty_toggle_en, out_enable} = 2'h1;
		ff_ctrl_code = 2'h0;
		pulse_wr(3);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "ff invert");
		ff_ctrl_code = 2'h2;
		pulse_wr(3);
		chk(16'h0000, {14'h0000, output_toggle_ff, pulse_out_pin}, "ff clear");
		ff_ctrl_code = 2'h1;
		pulse_wr(3);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "ff set");
		ff_ctrl_code = 2'h3;
		pulse_wr(3);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "ff keep");
		ff_ctrl_code = 2'h2;
		pulse_wr(3);
		// one-shot without delay: capture A starts it, period match ends it
		cap_a_toggle_en = 1'b1;
		capture_mode_field = 2'h1;
		u_pulse_source.drive(0, 1'b1, 4);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "one-shot start");
		period_wdata = capture_reg_a + 16'h0010;
		pulse_wr(1);
		period_toggle_en = 1'b1;
		wait_irq(1'b1);
		period_toggle_en = 1'b0;
		chk(16'h0000, {14'h0000, output_toggle_ff, pulse_out_pin}, "one-shot end");
		chk(16'h0011, up_counter - capture_reg_a, "one-shot width");
		// two enabled events in one cycle cancel, one alone toggles
		u_pulse_source.drive(0, 1'b0, 4);
		cap_b_toggle_en = 1'b1;
		u_pulse_source.drive(0, 1'b1, 0);
		u_pulse_source.drive(1, 1'b1, 4);
		chk(16'h0000, {14'h0000, output_toggle_ff, pulse_out_pin}, "paired events");
		u_pulse_source.drive(1, 1'b0, 4);
		u_pulse_source.drive(1, 1'b1, 4);
		chk(16'h0003, {14'h0000, output_toggle_ff, pulse_out_pin}, "cap b toggle");
		complete_run();
	end
endmodule
